// *** logic/psf_status_regs.sv ***
// Output-voltage, output-current and input status registers
`timescale 1ns/1ps
module psf_status_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Decoded command port
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_wdata,
  input wire logic clear_faults,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Active phase
  input wire psf_pkg::psf_phase_t phase_sel,
  // Output-voltage events, shared by all phases
  input wire logic ovp_fixed_evt,
  input wire logic ovp_track_evt,
  input wire logic ovp_prebias_evt,
  input wire logic ov_warn_evt,
  input wire logic uv_warn_evt,
  input wire logic uv_fault_evt,
  input wire logic vout_limit_evt,
  input wire logic ton_timeout_evt,
  // Per-phase events and input comparators
  input wire logic [psf_pkg::NUM_PHASES-1:0] oc_fault_evt,
  input wire logic [psf_pkg::NUM_PHASES-1:0] oc_warn_evt,
  input wire logic [psf_pkg::NUM_PHASES-1:0] in_ov_fault_evt,
  input wire logic [psf_pkg::NUM_PHASES-1:0] in_uv_warn_evt,
  input wire logic [psf_pkg::NUM_PHASES-1:0] in_above_on,
  input wire logic [psf_pkg::NUM_PHASES-1:0] in_below_off,
  // Alert masks
  input wire logic [7:0] vout_alert_mask,
  input wire logic [7:0] iout_alert_mask,
  input wire logic [7:0] input_alert_mask,
  input wire logic [psf_pkg::OVP_SRC_N-1:0] extended_alert_mask,
  // Alert and summaries
  output logic alert,
  output logic vout_summary,
  output logic iout_summary,
  output logic input_summary
);
  localparam int NP = psf_pkg::NUM_PHASES;

  typedef struct packed {
    logic [NP-1:0] off_live;
    logic [NP-1:0] seen_on;
    logic [psf_pkg::OVP_SRC_N-1:0] ovp_src;
    logic [7:0] rd_data;
    logic rd_valid;
    logic alert;
  } psf_regs_s;

  psf_regs_s st;
  psf_regs_s next_st;

  logic [7:0] vout_flags;
  logic [7:0] vout_set;
  logic [7:0] vout_clr;
  logic [NP-1:0][7:0] iout_flags;
  logic [NP-1:0][7:0] in_flags;
  logic [psf_pkg::OVP_SRC_N-1:0] ovp_evt;
  logic ovf_clr;
  logic vout_hit;
  logic iout_hit;
  logic input_hit;
  logic [7:0] input_view;

  assign vout_hit = cmd_code == psf_pkg::CMD_VOUT_STATUS;
  assign iout_hit = cmd_code == psf_pkg::CMD_IOUT_STATUS;
  assign input_hit = cmd_code == psf_pkg::CMD_INPUT_STATUS;

  // Overvoltage fault sources feed one flag
  always_comb begin
    ovp_evt = psf_pkg::OVP_SRC_RESET;
    ovp_evt[psf_pkg::OVP_FIXED_BIT] = ovp_fixed_evt;
    ovp_evt[psf_pkg::OVP_TRACK_BIT] = ovp_track_evt;
    ovp_evt[psf_pkg::OVP_PREBIAS_BIT] = ovp_prebias_evt;
  end

  always_comb begin
    vout_set = psf_pkg::READ_ZERO;
    vout_set[psf_pkg::VOUT_OV_FAULT_BIT] = |ovp_evt;
    vout_set[psf_pkg::VOUT_OV_WARN_BIT] = ov_warn_evt;
    vout_set[psf_pkg::VOUT_UV_WARN_BIT] = uv_warn_evt;
    vout_set[psf_pkg::VOUT_UV_FAULT_BIT] = uv_fault_evt;
    vout_set[psf_pkg::VOUT_LIMIT_BIT] = vout_limit_evt;
    vout_set[psf_pkg::VOUT_TON_BIT] = ton_timeout_evt;
  end

  // Shared across phases, so no phase qualifier on the write
  assign vout_clr = (cmd_wr && vout_hit) ? cmd_wdata : psf_pkg::READ_ZERO;
  assign ovf_clr = clear_faults | vout_clr[psf_pkg::VOUT_OV_FAULT_BIT];

  psf_flag_byte #(
    .SUPPORTED(psf_pkg::VOUT_SUPPORTED)
  ) u_vout_flags (
    .clk(clk),
    .reset_n(reset_n),
    .set_evt(vout_set),
    .clr_wr(vout_clr),
    .clr_all(clear_faults),
    .flags(vout_flags)
  );

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_phase
      logic [7:0] io_set;
      logic [7:0] io_clr;
      logic [7:0] in_set;
      logic [7:0] in_clr;
      logic sel;

      assign sel = phase_sel == psf_pkg::psf_phase_t'(p);

      always_comb begin
        io_set = psf_pkg::READ_ZERO;
        io_set[psf_pkg::IOUT_OC_FAULT_BIT] = oc_fault_evt[p];
        io_set[psf_pkg::IOUT_OC_WARN_BIT] = oc_warn_evt[p];
        in_set = psf_pkg::READ_ZERO;
        in_set[psf_pkg::IN_OV_FAULT_BIT] = in_ov_fault_evt[p];
        // Undervoltage warning stays quiet until the input first came on
        in_set[psf_pkg::IN_UV_WARN_BIT] =
          in_uv_warn_evt[p] & st.seen_on[p];
      end

      assign io_clr = (cmd_wr && iout_hit && sel) ?
        cmd_wdata : psf_pkg::READ_ZERO;
      assign in_clr = (cmd_wr && input_hit && sel) ?
        cmd_wdata : psf_pkg::READ_ZERO;

      psf_flag_byte #(
        .SUPPORTED(psf_pkg::IOUT_SUPPORTED)
      ) u_iout_flags (
        .clk(clk),
        .reset_n(reset_n),
        .set_evt(io_set),
        .clr_wr(io_clr),
        .clr_all(clear_faults),
        .flags(iout_flags[p])
      );

      psf_flag_byte #(
        .SUPPORTED(psf_pkg::INPUT_LATCHED)
      ) u_in_flags (
        .clk(clk),
        .reset_n(reset_n),
        .set_evt(in_set),
        .clr_wr(in_clr),
        .clr_all(clear_faults),
        .flags(in_flags[p])
      );
    end
  endgenerate

  // Input byte of the active phase with its live bit merged in
  always_comb begin
    input_view = in_flags[phase_sel] & psf_pkg::INPUT_LATCHED;
    input_view[psf_pkg::IN_OFF_LIVE_BIT] = st.off_live[phase_sel];
  end

  always_comb begin
    logic ovf_alert;
    logic [NP-1:0] ph_alert;
    ovf_alert = 1'b0;
    ph_alert = '0;
    next_st = st;
    // Live off indicator with turn-on and turn-off hysteresis
    for (int i = 0; i < NP; i++) begin
      if (in_above_on[i]) begin
        next_st.off_live[i] = 1'b0;
        next_st.seen_on[i] = 1'b1;
      end else if (in_below_off[i]) begin
        next_st.off_live[i] = 1'b1;
      end
      ph_alert[i] = |(iout_flags[i] & ~iout_alert_mask) |
        |(in_flags[i] & ~input_alert_mask);
    end
    // Per-source record of the overvoltage fault, cleared with its flag
    next_st.ovp_src = (st.ovp_src & ~{psf_pkg::OVP_SRC_N{ovf_clr}}) |
      ovp_evt;
    ovf_alert = !vout_alert_mask[psf_pkg::VOUT_OV_FAULT_BIT] &&
      |(st.ovp_src & ~extended_alert_mask);
    next_st.alert = ovf_alert |
      |(vout_flags & ~vout_alert_mask &
        ~(8'h01 << psf_pkg::VOUT_OV_FAULT_BIT)) |
      |ph_alert;
    next_st.rd_valid = cmd_rd;
    if (!cmd_rd) begin
      next_st.rd_data = st.rd_data;
    end else if (vout_hit) begin
      next_st.rd_data = vout_flags & psf_pkg::VOUT_SUPPORTED;
    end else if (iout_hit) begin
      next_st.rd_data = iout_flags[phase_sel] &
        psf_pkg::IOUT_SUPPORTED;
    end else if (input_hit) begin
      next_st.rd_data = input_view;
    end else begin
      next_st.rd_data = psf_pkg::READ_ZERO;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{off_live: {NP{psf_pkg::OFF_LIVE_RESET}},
              seen_on: '0,
              ovp_src: psf_pkg::OVP_SRC_RESET,
              rd_data: psf_pkg::READ_ZERO,
              rd_valid: 1'b0,
              alert: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign rd_valid = st.rd_valid;
  assign alert = st.alert;
  assign vout_summary = |vout_flags;
  assign iout_summary = |iout_flags[phase_sel];
  assign input_summary = |in_flags[phase_sel];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_rd_input;
    cmd_rd && input_hit;
  endsequence

  sequence s_fixed_ovp_unmasked;
    ovp_fixed_evt && !vout_alert_mask[psf_pkg::VOUT_OV_FAULT_BIT] &&
      !extended_alert_mask[psf_pkg::OVP_FIXED_BIT] &&
      !clear_faults && !(cmd_wr && vout_hit);
  endsequence

  sequence s_masks_hold;
    $stable(vout_alert_mask) && $stable(extended_alert_mask) &&
      !clear_faults && !(cmd_wr && vout_hit);
  endsequence

  AST_RD_INPUT:
  assert property (s_rd_input |=> rd_valid && rd_data == $past(input_view))
    else $error("input status read returned wrong byte");

  AST_RD_VOUT:
  assert property ((cmd_rd && vout_hit) |=>
    rd_valid && rd_data == ($past(vout_flags) & 8'hfc))
    else $error("output-voltage status read wrong");

  AST_OVP_ALERT:
  assert property (s_fixed_ovp_unmasked ##1 s_masks_hold |=> alert)
    else $error("unmasked overvoltage source gave no alert");

  AST_OVP_MASKED:
  assert property ((vout_alert_mask == 8'hff && iout_alert_mask == 8'hff &&
    input_alert_mask == 8'hff) [*2] |=> !alert)
    else $error("alert raised with every bit masked");

  AST_LIVE_ON:
  assert property (in_above_on[0] |=> !st.off_live[0] ##0
    (phase_sel != 1'b0 || input_view[psf_pkg::IN_OFF_LIVE_BIT] == 1'b0))
    else $error("live input bit not cleared when on");

  AST_UVW_GATED:
  assert property ((!st.seen_on[0] && !in_above_on[0]) |=>
    in_flags[0][5] == 1'b0 || $past(in_flags[0][5]))
    else $error("undervoltage warning before first turn-on");

  AST_PHASE_ISOLATION:
  assert property ((cmd_wr && iout_hit && phase_sel == 1'b1 &&
    !clear_faults) |=>
    ((iout_flags[0] & $past(iout_flags[0])) == $past(iout_flags[0])))
    else $error("write to one phase touched another");

  AST_SUMMARY:
  assert property ($rose(vout_flags[7]) |-> vout_summary ##1
    (vout_summary || $past(ovf_clr)))
    else $error("summary bit missed an output-voltage flag");

  AST_RD_IOUT_ZERO:
  assert property ((cmd_rd && iout_hit) |=>
    rd_valid && (rd_data & ~psf_pkg::IOUT_SUPPORTED) == 8'h00)
    else $error("unsupported output-current bit read as one");

  AST_RD_INPUT_ZERO:
  assert property ((cmd_rd && input_hit) |=>
    (rd_data & ~psf_pkg::INPUT_LATCHED &
      ~(8'h01 << psf_pkg::IN_OFF_LIVE_BIT)) == 8'h00)
    else $error("unsupported input bit read as one");
endmodule : psf_status_regs

// *** logic/psf_pkg.sv ***
// Constants and types shared by the power status flag register bank
package psf_pkg;
  // Command codes of the three status registers
  localparam logic [7:0] CMD_VOUT_STATUS = 8'h7a;
  localparam logic [7:0] CMD_IOUT_STATUS = 8'h7b;
  localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;

  // Output-voltage status bit positions
  localparam int VOUT_OV_FAULT_BIT = 7;
  localparam int VOUT_OV_WARN_BIT = 6;
  localparam int VOUT_UV_WARN_BIT = 5;
  localparam int VOUT_UV_FAULT_BIT = 4;
  localparam int VOUT_LIMIT_BIT = 3;
  localparam int VOUT_TON_BIT = 2;

  // Output-current status bit positions
  localparam int IOUT_OC_FAULT_BIT = 7;
  localparam int IOUT_OC_WARN_BIT = 5;

  // Input status bit positions
  localparam int IN_OV_FAULT_BIT = 7;
  localparam int IN_UV_WARN_BIT = 5;
  localparam int IN_OFF_LIVE_BIT = 3;

  // Latched bits that each register supports
  localparam logic [7:0] VOUT_SUPPORTED = 8'hfc;
  localparam logic [7:0] IOUT_SUPPORTED = 8'ha0;
  localparam logic [7:0] INPUT_LATCHED = 8'ha0;

  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic OFF_LIVE_RESET = 1'b1;

  // Overvoltage fault sources, one extended mask bit each
  localparam int OVP_SRC_N = 3;
  localparam int OVP_FIXED_BIT = 0;
  localparam int OVP_TRACK_BIT = 1;
  localparam int OVP_PREBIAS_BIT = 2;
  localparam logic [OVP_SRC_N-1:0] OVP_SRC_RESET = 3'h0;

  // Phases that keep their own output-current and input status
  localparam int NUM_PHASES = 2;
  localparam int PHASE_W = 1;
  typedef logic [PHASE_W-1:0] psf_phase_t;
endpackage : psf_pkg

// *** logic/psf_flag_byte.sv ***
// One byte of latched status flags with write-one and clear-all clearing
`timescale 1ns/1ps
module psf_flag_byte #(
  parameter logic [7:0] SUPPORTED = 8'hff
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Events and clears
  input wire logic [7:0] set_evt,
  input wire logic [7:0] clr_wr,
  input wire logic clr_all,
  // Latched flags
  output logic [7:0] flags
);
  typedef struct packed {
    logic [7:0] flags;
  } psf_cell_s;

  psf_cell_s st;
  psf_cell_s next_st;

  always_comb begin
    next_st = st;
    // Clears first, then events, so a same-cycle event survives
    next_st.flags = st.flags & ~clr_wr;
    if (clr_all) begin
      next_st.flags = psf_pkg::FLAGS_RESET;
    end
    next_st.flags = (next_st.flags | set_evt) & SUPPORTED;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{flags: psf_pkg::FLAGS_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign flags = st.flags;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  AST_SET_WINS:
  assert property ((|(set_evt & SUPPORTED)) |=>
    ((flags & $past(set_evt) & SUPPORTED) == ($past(set_evt) & SUPPORTED)))
    else $error("event lost against a clear");

  AST_WRITE_ONE_CLEARS:
  assert property (((clr_wr & ~set_evt & flags) != 8'h00) |=>
    ((flags & $past(clr_wr) & ~$past(set_evt)) == 8'h00))
    else $error("written one did not clear flag");

  AST_CLEAR_ALL:
  assert property ((clr_all && set_evt == 8'h00) |=> flags == 8'h00)
    else $error("clear all left a flag set");

  AST_HOLD:
  assert property ((!clr_all && clr_wr == 8'h00) |=>
    ((flags & $past(flags)) == $past(flags)))
    else $error("flag dropped without a clear");

  AST_UNSUPPORTED_ZERO:
  assert property ((flags & ~SUPPORTED) == 8'h00)
    else $error("unsupported bit set");
endmodule : psf_flag_byte

// *** test/psf_host_model.sv ***
// Host model driving byte reads, writes and clear-all on the command port
`timescale 1ns/1ps
module psf_host_model (
  // Clock
  input wire logic clk,
  // Command port
  output logic [7:0] cmd_code,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_wdata,
  output logic clear_faults,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 8'h00;
    clear_faults = 1'b0;
  end

  // Answer is taken one cycle after the request; code released inverted
  task automatic rd(input logic [7:0] code, output logic [7:0] data,
                    output logic vld);
    @(negedge clk);
    cmd_code = code;
    cmd_rd = 1'b1;
    @(negedge clk);
    cmd_rd = 1'b0;
    cmd_code = ~code;
    data = rd_data;
    vld = rd_valid;
  endtask : rd

  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(negedge clk);
    cmd_code = code;
    cmd_wdata = data;
    cmd_wr = 1'b1;
    @(negedge clk);
    cmd_wr = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~data;
  endtask : wr

  task automatic clr();
    @(negedge clk);
    clear_faults = 1'b1;
    @(negedge clk);
    clear_faults = 1'b0;
  endtask : clr
endmodule : psf_host_model

// *** test/psf_status_regs_bench.sv ***
// Self-checking bench for the power status flag registers
`timescale 1ns/1ps
module psf_status_regs_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] cmd_code, cmd_wdata, rd_data;
  logic cmd_wr, cmd_rd, clear_faults, rd_valid;
  logic alert, vout_summary, iout_summary, input_summary;
  logic [7:0] vout_ev = 8'h00;
  logic [1:0] ovp_tp = 2'h0;
  logic [0:0] phase = 1'h0;
  logic [1:0] oc_f = 2'h0, oc_w = 2'h0, in_ovf = 2'h0, in_uvw = 2'h0;
  logic [1:0] above = 2'h0, below = 2'h3;
  logic [7:0] vmask = 8'hff, imask = 8'hff, nmask = 8'hff;
  logic [2:0] xmask = 3'h7;
  int n_mismatch = 0;
  int n_compared = 0;

  always #10 clk = ~clk;

  psf_host_model u_psf_host_model (.clk(clk), .cmd_code(cmd_code),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_wdata(cmd_wdata),
    .clear_faults(clear_faults), .rd_data(rd_data), .rd_valid(rd_valid));

  psf_status_regs u_psf_status_regs (.clk(clk), .reset_n(reset_n),
    .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_wdata(cmd_wdata), .clear_faults(clear_faults),
    .rd_data(rd_data), .rd_valid(rd_valid), .phase_sel(phase),
    .ovp_fixed_evt(vout_ev[7]), .ovp_track_evt(ovp_tp[0]),
    .ovp_prebias_evt(ovp_tp[1]), .ov_warn_evt(vout_ev[6]),
    .uv_warn_evt(vout_ev[5]), .uv_fault_evt(vout_ev[4]),
    .vout_limit_evt(vout_ev[3]), .ton_timeout_evt(vout_ev[2]),
    .oc_fault_evt(oc_f), .oc_warn_evt(oc_w), .in_ov_fault_evt(in_ovf),
    .in_uv_warn_evt(in_uvw), .in_above_on(above), .in_below_off(below),
    .vout_alert_mask(vmask), .iout_alert_mask(imask),
    .input_alert_mask(nmask), .extended_alert_mask(xmask),
    .alert(alert), .vout_summary(vout_summary),
    .iout_summary(iout_summary), .input_summary(input_summary));

  task automatic give_verdict();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rchk(logic [7:0] code, logic [7:0] exp);
    logic [7:0] d;
    logic v;
    u_psf_host_model.rd(code, d, v);
    chk("rd_valid", 8'h01, {7'h00, v});
    chk("rd_data", exp, d);
  endtask : rchk

  // One-cycle event pulse driven from the falling edge
  task automatic pulse(logic [7:0] v, logic [1:0] f, logic [1:0] w,
                       logic [1:0] o, logic [1:0] u);
    @(negedge clk);
    vout_ev = v;
    oc_f = f;
    oc_w = w;
    in_ovf = o;
    in_uvw = u;
    @(negedge clk);
    vout_ev = 8'h00;
    {oc_f, oc_w, in_ovf, in_uvw} = 8'h00;
  endtask : pulse

  task automatic t_reset();
    chk("alert", 8'h00, {7'h00, alert});
    rchk(8'h7a, 8'h00);
    rchk(8'h7b, 8'h00);
    rchk(8'h7c, 8'h08);
    pulse(8'h00, 2'h0, 2'h0, 2'h0, 2'h1);
    rchk(8'h7c, 8'h08);
    rchk(8'h7d, 8'h00);
  endtask : t_reset

  task automatic t_vout();
    logic [7:0] b;
    for (int i = 2; i < 8; i++) begin
      b = 8'h01 << i;
      pulse(b, 2'h0, 2'h0, 2'h0, 2'h0);
      rchk(8'h7a, b);
      chk("vout_summary", 8'h01, {7'h00, vout_summary});
      u_psf_host_model.wr(8'h7a, ~b);
      rchk(8'h7a, b);
      u_psf_host_model.wr(8'h7a, 8'hff);
      rchk(8'h7a, 8'h00);
    end
  endtask : t_vout

  task automatic t_iout();
    pulse(8'h00, 2'h1, 2'h2, 2'h0, 2'h0);
    rchk(8'h7b, 8'h80);
    chk("iout_summary", 8'h01, {7'h00, iout_summary});
    phase = 1'h1;
    rchk(8'h7b, 8'h20);
    imask = 8'hdf;
    repeat (2) @(negedge clk);
    chk("alert", 8'h01, {7'h00, alert});
    imask = 8'hff;
    u_psf_host_model.wr(8'h7b, 8'hff);
    rchk(8'h7b, 8'h00);
    phase = 1'h0;
    rchk(8'h7b, 8'h80);
    u_psf_host_model.clr();
    rchk(8'h7b, 8'h00);
  endtask : t_iout

  task automatic t_input();
    @(negedge clk);
    above = 2'h1;
    below = 2'h2;
    pulse(8'h00, 2'h0, 2'h0, 2'h1, 2'h3);
    rchk(8'h7c, 8'ha0);
    chk("input_summary", 8'h01, {7'h00, input_summary});
    nmask = 8'h7f;
    repeat (2) @(negedge clk);
    chk("alert", 8'h01, {7'h00, alert});
    nmask = 8'hff;
    phase = 1'h1;
    rchk(8'h7c, 8'h08);
    phase = 1'h0;
    u_psf_host_model.wr(8'h7c, 8'hff);
    rchk(8'h7c, 8'h00);
    above = 2'h0;
    below = 2'h3;
    rchk(8'h7c, 8'h08);
    chk("input_summary", 8'h00, {7'h00, input_summary});
  endtask : t_input

  task automatic t_alert();
    vmask = 8'h00;
    xmask = 3'h2;
    pulse(8'h00, 2'h0, 2'h0, 2'h0, 2'h0);
    ovp_tp = 2'h1;
    @(negedge clk);
    ovp_tp = 2'h0;
    repeat (3) @(negedge clk);
    chk("alert", 8'h00, {7'h00, alert});
    pulse(8'h80, 2'h0, 2'h0, 2'h0, 2'h0);
    @(negedge clk);
    chk("alert", 8'h01, {7'h00, alert});
    vmask = 8'h80;
    repeat (2) @(negedge clk);
    chk("alert", 8'h00, {7'h00, alert});
    u_psf_host_model.clr();
    vmask = 8'h00;
    xmask = 3'h4;
    ovp_tp = 2'h2;
    @(negedge clk);
    ovp_tp = 2'h0;
    repeat (3) @(negedge clk);
    chk("alert", 8'h00, {7'h00, alert});
    xmask = 3'h3;
    repeat (2) @(negedge clk);
    chk("alert", 8'h01, {7'h00, alert});
    u_psf_host_model.clr();
    vmask = 8'hff;
    xmask = 3'h7;
  endtask : t_alert

  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_vout();
    t_iout();
    t_input();
    t_alert();
    give_verdict();
  end

  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule : psf_status_regs_bench
